// file: lic_combine.sv
// Combining logic for one logic input: contact and virtual state merged by
// the selection. Contact-less inputs accept only the virtual choices.
// Assumes selection and states come from flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lic_combine
  import lic_pkg::*;
#(
  parameter bit HAS_CONTACT = 1'b1
) (
  input wire logic closed, // Debounced contact closed
  input wire logic von, // Virtual input on
  input wire logic [LIC_SEL_W-1:0] sel, // Combining selection
  output logic asserted // Logic input asserted
);
  // Combined groups run close-on, close-off, open-on, open-off from 5 up
  wire [LIC_SEL_W-1:0] sel_m1 = sel - 5'h01;
  wire c_cond = sel_m1[1] ? ~closed : closed;
  wire v_cond = sel_m1[0] ? ~von : von;
  logic full;

  always_comb begin
    case (lic_sel_t'(sel))
      LIC_DISABLED: full = 1'b0;
      LIC_CONT_CLOSE: full = closed;
      LIC_CONT_OPEN: full = ~closed;
      LIC_VIRT_ON: full = von;
      LIC_VIRT_OFF: full = ~von;
      LIC_C_AND_VON, LIC_C_AND_VOFF, LIC_O_AND_VON, LIC_O_AND_VOFF:
        full = c_cond & v_cond;
      LIC_C_OR_VON, LIC_C_OR_VOFF, LIC_O_OR_VON, LIC_O_OR_VOFF:
        full = c_cond | v_cond;
      LIC_C_XOR_VON, LIC_C_XOR_VOFF, LIC_O_XOR_VON, LIC_O_XOR_VOFF:
        full = c_cond ^ v_cond;
      default: full = 1'b0;
    endcase
  end

  // Virtual-only inputs: disabled, on or off; anything else never asserts
  wire virt_only = (lic_sel_t'(sel) == LIC_VIRT_ON) ? von :
                   (lic_sel_t'(sel) == LIC_VIRT_OFF) ? ~von : 1'b0;

  assign asserted = HAS_CONTACT ? full : virt_only;
endmodule
`default_nettype wire

// file: lic_debounce.sv
// One contact debouncer: a new level is accepted only after it has stayed
// stable for one power cycle, counted in system clocks.
// Assumes the raw pin is asynchronous; it is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module lic_debounce
  import lic_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_b, // Synchronous reset, low
  input wire logic raw_in, // Raw contact pin, high = closed
  input wire logic [LIC_CNT_W-1:0] period, // Clocks in one power cycle
  output logic closed // Debounced state
);
  logic sync1_r, sync2_r;
  logic [LIC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic closed_r;
  wire differs = sync2_r != closed_r;
  wire expired = cnt_r >= period - 22'h00_0001;

  assign cnt_nxt = (!differs) ? '0 : (cnt_r + 22'h00_0001);
  assign closed = closed_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r <= '0;
      closed_r <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
      cnt_r <= (differs && expired) ? '0 : cnt_nxt;
      if (differs && expired) begin
        closed_r <= sync2_r;
      end
    end
  end

  // Level only changes after a full stable count
  property p_stable_change;
    @(posedge sys_clk) disable iff (!rst_b)
    (closed_r != $past(closed_r)) |-> ($past(cnt_r) >= $past(period) - 1);
  endproperty
  a_stable_change: assert property (p_stable_change)
    else $error("debounced level changed before one power cycle");

  property p_glitch_blocked;
    @(posedge sys_clk) disable iff (!rst_b)
    (!differs && period > 22'h00_0004) ##1 differs ##1 !differs
      |-> ##1 $stable(closed_r);
  endproperty
  a_glitch_blocked: assert property (p_glitch_blocked)
    else $error("short glitch changed debounced level");
endmodule
`default_nettype wire

// file: lic_field.sv
// Field contact model for the logic input combiner bench.
// Assumes contacts rest open and close only for commanded short glitches.
`timescale 1ns/1ps
`default_nettype none
module lic_field
  import lic_pkg::*;
(
  input wire logic sys_clk, // Bench clock
  input wire logic rst_b, // Synchronous reset, low
  input wire logic go, // Start one glitch
  input wire logic [LIC_NUM_CONTACT-1:0] mask, // Contacts that glitch
  input wire logic [15:0] len, // Glitch length in clocks
  output logic [LIC_NUM_CONTACT-1:0] contact_in, // Contact pins
  output logic busy // Glitch in progress
);
  logic [15:0] cnt_r;

  // ==========================================================
  // Glitch generator, always far shorter than one power cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt_r <= 16'h0000;
      contact_in <= '0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      cnt_r <= len;
      contact_in <= mask;
    end else if (busy) begin
      if (cnt_r == 16'h0000) begin
        busy <= 1'b0;
        contact_in <= '0;
      end else begin
        cnt_r <= cnt_r - 16'h0001;
        contact_in <= mask & {LIC_NUM_CONTACT{cnt_r[1]}};
      end
    end
  end
endmodule
`default_nettype wire

// file: lic_pkg.sv
// Package for the logic input combiner: sizes, offsets, reset values,
// combining selections and the carrier structs.
// Assumes a 100 MHz system clock and a plain strobe register port.
package lic_pkg;

  localparam int LIC_NUM_LOGIC = 20;
  localparam int LIC_NUM_CONTACT = 14;
  localparam int LIC_WORD_W = 16;
  localparam int LIC_SEL_W = 5;
  localparam int LIC_ADDR_W = 8;

  localparam int LIC_CLK_HZ = 100_000_000;
  localparam int LIC_FREQ_MIN_HZ = 25;
  localparam int LIC_FREQ_MAX_HZ = 60;
  localparam logic [6:0] LIC_FREQ_RST = 7'h3C;
  localparam int LIC_CYCLE_CNT_MAX = LIC_CLK_HZ / LIC_FREQ_MIN_HZ;
  localparam int LIC_CNT_W = 22;

  localparam int LIC_MOM_MIN_MS = 50;
  localparam int LIC_MOM_MAX_MS = 200;

  localparam logic [LIC_ADDR_W-1:0] LIC_VIRT_BASE = 8'h90;
  localparam logic [LIC_ADDR_W-1:0] LIC_VIRT_LAST = 8'hA4;
  localparam logic [LIC_ADDR_W-1:0] LIC_SEL_BASE = 8'h40;
  localparam logic [LIC_ADDR_W-1:0] LIC_FREQ_ADDR = 8'h60;
  localparam logic [LIC_ADDR_W-1:0] LIC_BRK_ADDR = 8'h61;
  localparam logic [LIC_ADDR_W-1:0] LIC_CONT_ADDR = 8'h62;
  localparam logic [LIC_ADDR_W-1:0] LIC_LOGIC_ADDR = 8'h63;
  localparam logic [LIC_ADDR_W-1:0] LIC_STAT_ADDR = 8'h64;

  localparam logic [LIC_WORD_W-1:0] LIC_VIRT_RST = 16'h0000;
  localparam logic [LIC_SEL_W-1:0] LIC_SEL_RST = 5'h00;
  localparam logic [LIC_WORD_W-1:0] LIC_READ_ZERO = 16'h0000;

  typedef enum logic [LIC_SEL_W-1:0] {
    LIC_DISABLED, LIC_CONT_CLOSE, LIC_CONT_OPEN, LIC_VIRT_ON, LIC_VIRT_OFF,
    LIC_C_AND_VON, LIC_C_AND_VOFF, LIC_O_AND_VON, LIC_O_AND_VOFF,
    LIC_C_OR_VON, LIC_C_OR_VOFF, LIC_O_OR_VON, LIC_O_OR_VOFF,
    LIC_C_XOR_VON, LIC_C_XOR_VOFF, LIC_O_XOR_VON, LIC_O_XOR_VOFF
  } lic_sel_t;

  // One register port access
  typedef struct packed {
    logic [LIC_ADDR_W-1:0] addr;
    logic [LIC_WORD_W-1:0] wdata;
    logic wr;
    logic rd;
  } lic_bus_t;

  // Breaker aux contact configuration: enable and logic input index
  typedef struct packed {
    logic a_en;
    logic [4:0] a_idx;
    logic b_en;
    logic [4:0] b_idx;
  } lic_brk_t;

endpackage

// file: lic_top.sv
// Logic input combiner top: debounced contact inputs, stored virtual
// inputs, per-input combining selection and breaker-function gating.
// Assumes a register master on the same clock with one-cycle strobes.
//
// Functional notes
// - Twenty logic inputs, each asserted or not asserted.
// - Fourteen contact inputs sampled, each open or closed.
// - Contacts debounced one power cycle; shorter disturbances ignored.
// - Twenty virtual words; zero is off, nonzero is on.
// - Virtual words kept through power loss, at words 0090 to 00A3.
// - Virtual words writable from serial port and front panel.
// - Inputs 1 to 14 combine same-index contact and virtual state.
// - Seventeen selections for inputs 1 to 14.
// - Single-source selections: closed, open, on or off.
// - AND selections: contact and virtual condition both hold.
// - OR selections: either condition holds.
// - XOR selections: exactly one condition holds.
// - Inputs 15 to 20 use virtual input only: disabled, on, off.
// - Asserted input invokes every function mapped to it.
// - No breaker aux contact configured: breaker functions disabled.
// - Nominal frequency 25 to 60 Hz in 1 Hz steps.
`timescale 1ns/1ps
`default_nettype none
module lic_top
  import lic_pkg::*;
#(
  parameter int NUM_LOGIC = LIC_NUM_LOGIC,
  parameter int NUM_CONTACT = LIC_NUM_CONTACT
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_b, // Synchronous reset, low
  input wire logic [NUM_CONTACT-1:0] contact_in, // Raw contact pins
  input wire logic [LIC_ADDR_W-1:0] reg_addr, // Serial port address
  input wire logic [LIC_WORD_W-1:0] reg_wdata, // Serial port write data
  input wire logic reg_wr, // Serial port write strobe
  input wire logic reg_rd, // Serial port read strobe
  input wire logic [4:0] panel_idx, // Front panel virtual index
  input wire logic [LIC_WORD_W-1:0] panel_wdata, // Front panel value
  input wire logic panel_wr, // Front panel write strobe
  input wire logic nv_load, // Restore virtual word from storage
  input wire logic [4:0] nv_idx, // Restore index
  input wire logic [LIC_WORD_W-1:0] nv_data, // Restore value
  output logic [LIC_WORD_W-1:0] reg_rdata, // Read data, next cycle
  output logic [NUM_LOGIC-1:0] logic_asserted, // Logic input states
  output logic [NUM_CONTACT-1:0] contact_closed, // Debounced contacts
  output logic nv_save, // Virtual word changed, store it
  output logic [4:0] nv_save_idx, // Index to store
  output logic [LIC_WORD_W-1:0] nv_save_data, // Value to store
  output logic breaker_funcs_en, // Breaker functions permitted
  output logic breaker_closed, // Breaker reported closed
  output logic breaker_open, // Breaker reported open
  output logic breaker_fail_alarm_rec // Failure alarm recommended
);

  // ==========================================================
  // Decoding
  // ==========================================================
  function automatic logic in_span(input logic [LIC_ADDR_W-1:0] a,
                                   input logic [LIC_ADDR_W-1:0] base,
                                   input int n);
    in_span = (a >= base) && (32'(a) < 32'(base) + n);
  endfunction

  function automatic logic [4:0] idx_of(input logic [LIC_ADDR_W-1:0] a,
                                        input logic [LIC_ADDR_W-1:0] base);
    logic [LIC_ADDR_W-1:0] d;
    d = a - base;
    idx_of = d[4:0];
  endfunction

  lic_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire hit_virt = in_span(bus.addr, LIC_VIRT_BASE, NUM_LOGIC);
  wire hit_sel = in_span(bus.addr, LIC_SEL_BASE, NUM_LOGIC);
  wire [4:0] bus_idx = hit_virt ? idx_of(bus.addr, LIC_VIRT_BASE)
                                : idx_of(bus.addr, LIC_SEL_BASE);

  // ==========================================================
  // Storage
  // ==========================================================
  logic [LIC_WORD_W-1:0] virt_r [NUM_LOGIC];
  logic [LIC_SEL_W-1:0] sel_r [NUM_LOGIC];
  logic [6:0] freq_r;
  lic_brk_t brk_r;
  logic [LIC_WORD_W-1:0] rdata_r;
  logic [NUM_LOGIC-1:0] asserted_r;
  logic [NUM_CONTACT-1:0] closed_r;
  logic nv_save_r;
  logic [4:0] nv_idx_r;
  logic [LIC_WORD_W-1:0] nv_data_r;
  logic brk_en_r, brk_cl_r, brk_op_r, alarm_r;
  logic [LIC_CNT_W-1:0] period_r;

  // Serial write wins over the panel in the same cycle
  wire bus_vwr = bus.wr && hit_virt;
  wire vwr = bus_vwr || panel_wr || nv_load;
  wire [4:0] vidx = bus_vwr ? bus_idx : panel_wr ? panel_idx : nv_idx;
  wire [LIC_WORD_W-1:0] vdata = bus_vwr ? bus.wdata :
                                panel_wr ? panel_wdata : nv_data;
  wire vidx_ok = 32'(vidx) < NUM_LOGIC;

  // Frequency write clamped into 25..60 Hz
  wire [6:0] freq_in = bus.wdata[6:0];
  wire [6:0] freq_nxt =
    (32'(freq_in) < LIC_FREQ_MIN_HZ) ? 7'(LIC_FREQ_MIN_HZ) :
    (32'(freq_in) > LIC_FREQ_MAX_HZ) ? 7'(LIC_FREQ_MAX_HZ) : freq_in;
  wire [LIC_CNT_W-1:0] period_nxt = LIC_CNT_W'(LIC_CLK_HZ / 32'(freq_r));

  logic [NUM_LOGIC-1:0] von;
  logic [NUM_LOGIC-1:0] asserted_w;
  logic [NUM_CONTACT-1:0] closed_w;

  genvar g;
  generate
    for (g = 0; g < NUM_LOGIC; g++) begin : g_in
      assign von[g] = virt_r[g] != LIC_VIRT_RST;
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          virt_r[g] <= LIC_VIRT_RST;
          sel_r[g] <= LIC_SEL_RST;
        end else begin
          if (vwr && vidx_ok && 32'(vidx) == g) begin
            virt_r[g] <= vdata;
          end
          if (bus.wr && hit_sel && 32'(bus_idx) == g) begin
            sel_r[g] <= bus.wdata[LIC_SEL_W-1:0];
          end
        end
      end
      if (g < NUM_CONTACT) begin : g_ct
        lic_debounce u_deb (
          .sys_clk(sys_clk),
          .rst_b(rst_b),
          .raw_in(contact_in[g]),
          .period(period_r),
          .closed(closed_w[g])
        );
        lic_combine #(.HAS_CONTACT(1'b1)) u_cmb (
          .closed(closed_w[g]),
          .von(von[g]),
          .sel(sel_r[g]),
          .asserted(asserted_w[g])
        );
      end else begin : g_vo
        lic_combine #(.HAS_CONTACT(1'b0)) u_cmb (
          .closed(1'b0),
          .von(von[g]),
          .sel(sel_r[g]),
          .asserted(asserted_w[g])
        );
      end
    end
  endgenerate

  // ==========================================================
  // Breaker state from aux contacts on contact-backed inputs
  // ==========================================================
  wire a_ok = brk_r.a_en && 32'(brk_r.a_idx) < NUM_CONTACT;
  wire b_ok = brk_r.b_en && 32'(brk_r.b_idx) < NUM_CONTACT;
  wire breaker_aux_contact_a = a_ok && asserted_w[brk_r.a_idx];
  wire breaker_aux_contact_b = b_ok && asserted_w[brk_r.b_idx];
  wire funcs_en = a_ok || b_ok;
  wire cl_w = a_ok ? breaker_aux_contact_a :
              (b_ok && !breaker_aux_contact_b);
  wire op_w = b_ok ? breaker_aux_contact_b :
              (a_ok && !breaker_aux_contact_a);

  // ==========================================================
  // Read mux
  // ==========================================================
  logic [LIC_WORD_W-1:0] rd_mux;
  always_comb begin
    rd_mux = LIC_READ_ZERO;
    if (hit_virt) begin
      rd_mux = virt_r[bus_idx];
    end else if (hit_sel) begin
      rd_mux = LIC_WORD_W'(sel_r[bus_idx]);
    end else if (bus.addr == LIC_FREQ_ADDR) begin
      rd_mux = LIC_WORD_W'(freq_r);
    end else if (bus.addr == LIC_BRK_ADDR) begin
      rd_mux = LIC_WORD_W'(brk_r);
    end else if (bus.addr == LIC_CONT_ADDR) begin
      rd_mux = LIC_WORD_W'(closed_r);
    end else if (bus.addr == LIC_LOGIC_ADDR) begin
      rd_mux = asserted_r[LIC_WORD_W-1:0];
    end else if (bus.addr == LIC_STAT_ADDR) begin
      rd_mux = {asserted_r[NUM_LOGIC-1:LIC_WORD_W],
                brk_op_r, brk_cl_r, brk_en_r,
                {(LIC_WORD_W-3-NUM_LOGIC+LIC_WORD_W){1'b0}}};
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      freq_r <= LIC_FREQ_RST;
      period_r <= LIC_CNT_W'(LIC_CLK_HZ / 60);
      brk_r <= '0;
      rdata_r <= LIC_READ_ZERO;
      asserted_r <= '0;
      closed_r <= '0;
      nv_save_r <= 1'b0;
      nv_idx_r <= '0;
      nv_data_r <= LIC_VIRT_RST;
      brk_en_r <= 1'b0;
      brk_cl_r <= 1'b0;
      brk_op_r <= 1'b0;
      alarm_r <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == LIC_FREQ_ADDR) begin
        freq_r <= freq_nxt;
      end
      if (bus.wr && bus.addr == LIC_BRK_ADDR) begin
        brk_r <= bus.wdata[11:0];
      end
      period_r <= period_nxt;
      rdata_r <= bus.rd ? rd_mux : LIC_READ_ZERO;
      asserted_r <= asserted_w;
      closed_r <= closed_w;
      nv_save_r <= (bus_vwr || panel_wr) && vidx_ok;
      nv_idx_r <= vidx;
      nv_data_r <= vdata;
      brk_en_r <= funcs_en;
      brk_cl_r <= funcs_en && cl_w;
      brk_op_r <= funcs_en && op_w;
      alarm_r <= funcs_en;
    end
  end

  assign reg_rdata = rdata_r;
  assign logic_asserted = asserted_r;
  assign contact_closed = closed_r;
  assign nv_save = nv_save_r;
  assign nv_save_idx = nv_idx_r;
  assign nv_save_data = nv_data_r;
  assign breaker_funcs_en = brk_en_r;
  assign breaker_closed = brk_cl_r;
  assign breaker_open = brk_op_r;
  assign breaker_fail_alarm_rec = alarm_r;

  // ==========================================================
  // Checks
  // ==========================================================
  property p_virt_store;
    @(posedge sys_clk) disable iff (!rst_b)
    (bus.wr && hit_virt) |=> (virt_r[$past(bus_idx)] == $past(bus.wdata));
  endproperty
  a_virt_store: assert property (p_virt_store)
    else $error("serial virtual write not stored");

  property p_von_level;
    @(posedge sys_clk) disable iff (!rst_b)
    (bus.wr && hit_virt && bus.wdata == 16'h0000) |=> !von[$past(bus_idx)];
  endproperty
  a_von_level: assert property (p_von_level)
    else $error("zero virtual word reads as on");

  property p_nv_save;
    @(posedge sys_clk) disable iff (!rst_b)
    (bus.wr && hit_virt) |=> (nv_save && nv_save_idx == $past(bus_idx));
  endproperty
  a_nv_save: assert property (p_nv_save)
    else $error("virtual write not passed to storage");

  property p_virt_only;
    @(posedge sys_clk) disable iff (!rst_b)
    (sel_r[NUM_LOGIC-1] == LIC_SEL_W'(LIC_VIRT_ON))
      |=> logic_asserted[NUM_LOGIC-1] == $past(von[NUM_LOGIC-1]);
  endproperty
  a_virt_only: assert property (p_virt_only)
    else $error("virtual-only input does not follow virtual on");

  property p_disabled;
    @(posedge sys_clk) disable iff (!rst_b)
    (sel_r[0] == LIC_SEL_W'(LIC_DISABLED)) |=> !logic_asserted[0];
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled input asserted");

  property p_and0;
    @(posedge sys_clk) disable iff (!rst_b)
    (sel_r[0] == LIC_SEL_W'(LIC_C_AND_VON))
      |=> logic_asserted[0] == ($past(closed_w[0]) && $past(von[0]));
  endproperty
  a_and0: assert property (p_and0)
    else $error("AND selection wrong on input one");

  property p_brk_gate;
    @(posedge sys_clk) disable iff (!rst_b)
    (!brk_r.a_en && !brk_r.b_en)
      |=> (!breaker_funcs_en && !breaker_closed && !breaker_open);
  endproperty
  a_brk_gate: assert property (p_brk_gate)
    else $error("breaker functions active with no aux contact");

  property p_freq_range;
    @(posedge sys_clk) disable iff (!rst_b)
    1'b1 |-> (freq_r >= 7'd25 && freq_r <= 7'd60);
  endproperty
  a_freq_range: assert property (p_freq_range)
    else $error("nominal frequency out of range");
endmodule
`default_nettype wire

// file: lic_top_tb.sv
// Self-checking bench for lic_top with a model of words and selections.
// Assumes contacts stay open apart from short glitches from lic_field.
`timescale 1ns/1ps
`default_nettype none
module lic_top_tb;
  import lic_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [4:0] panel_idx = 5'h00;
  logic [15:0] panel_wdata = 16'h0000;
  logic panel_wr = 1'b0;
  logic nv_load = 1'b0;
  logic [4:0] nv_idx = 5'h00;
  logic [15:0] nv_data = 16'h0000;
  logic g_go = 1'b0;
  logic [13:0] g_mask = 14'h0000;
  logic [15:0] g_len = 16'h0000;
  logic g_busy, nv_save, b_en, b_cl, b_op, b_al;
  logic [13:0] contact_in, contact_closed;
  logic [15:0] reg_rdata, nv_save_data, rv;
  logic [19:0] logic_asserted;
  logic [4:0] nv_save_idx;
  int vmod[20];
  int smod[20];
  int n_mismatch = 0;
  int checks_done = 0;

  always #5 sys_clk = ~sys_clk;

  lic_field field (.sys_clk(sys_clk), .rst_b(rst_b), .go(g_go),
    .mask(g_mask), .len(g_len), .contact_in(contact_in), .busy(g_busy));

  lic_top dut (.sys_clk(sys_clk), .rst_b(rst_b), .contact_in(contact_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .panel_idx(panel_idx), .panel_wdata(panel_wdata),
    .panel_wr(panel_wr), .nv_load(nv_load), .nv_idx(nv_idx),
    .nv_data(nv_data), .reg_rdata(reg_rdata),
    .logic_asserted(logic_asserted), .contact_closed(contact_closed),
    .nv_save(nv_save), .nv_save_idx(nv_save_idx),
    .nv_save_data(nv_save_data), .breaker_funcs_en(b_en),
    .breaker_closed(b_cl), .breaker_open(b_op),
    .breaker_fail_alarm_rec(b_al));

  // ==========================================================
  // Compare tasks and closing
  task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_vec(input logic [19:0] e, input logic [19:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Reference model, contacts always open
  function automatic logic [19:0] exp_logic();
    logic [19:0] r;
    logic cc, vc;
    int s;
    r = '0;
    for (int i = 0; i < 20; i++) begin
      s = smod[i];
      cc = s inside {2, 7, 8, 11, 12, 15, 16};
      vc = (vmod[i] != 0) ^ (s inside {4, 6, 8, 10, 12, 14, 16});
      case (s)
        1, 2: r[i] = cc;
        3, 4: r[i] = vc;
        5, 6, 7, 8: r[i] = cc & vc;
        9, 10, 11, 12: r[i] = cc | vc;
        13, 14, 15, 16: r[i] = cc ^ vc;
        default: r[i] = 1'b0;
      endcase
    end
    return r;
  endfunction

  // ==========================================================
  // Register port and panel tasks
  task automatic saved(input int i, input logic [15:0] d);
    vmod[i] = d;
    chk_word(16'h0001, {15'h0000, nv_save});
    chk_word(16'(i), {11'h000, nv_save_idx});
    chk_word(d, nv_save_data);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
    if (a >= LIC_VIRT_BASE && a < LIC_VIRT_LAST) saved(a - LIC_VIRT_BASE, d);
    if (a >= LIC_SEL_BASE && a < 8'h54) smod[a - LIC_SEL_BASE] = d;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk_word(e, reg_rdata);
  endtask

  task automatic tick_chk();
    @(posedge sys_clk);
    #1;
    chk_vec(exp_logic(), logic_asserted);
  endtask

  // ==========================================================
  // Tests
  initial begin
    int cfg[6];
    logic aok, bok, la, lb, en, ecl, eop;
    logic [19:0] l;
    cfg = '{0, 16'h0880, 16'h0023, 16'h08A3, 16'h0BC0, 16'h0033};
    void'($urandom(65371));
    for (int i = 0; i < 20; i++) begin
      vmod[i] = 0;
      smod[i] = 0;
    end
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      rchk(8'(LIC_VIRT_BASE + i), 16'h0000);
      rchk(8'(LIC_SEL_BASE + i), 16'h0000);
    end
    rchk(LIC_VIRT_LAST, 16'h0000);
    rchk(LIC_FREQ_ADDR, 16'h003C);
    chk_vec(20'h0_0000, logic_asserted);
    $display("test reset done");
    foreach (cfg[k]) begin
      wr(LIC_FREQ_ADDR, 16'(k * 11 + 14));
      rchk(LIC_FREQ_ADDR, 16'(k < 2 ? 25 : (k > 4 ? 60 : k * 11 + 14)));
    end
    wr(LIC_FREQ_ADDR, 16'h003C);
    $display("test frequency done");
    for (int i = 0; i < 20; i++) begin
      for (int s = 0; s < 17; s++) begin
        if (i >= 14 && !(s inside {0, 3, 4})) continue;
        wr(8'(LIC_SEL_BASE + i), 16'(s));
        rchk(8'(LIC_SEL_BASE + i), 16'(s));
        for (int k = 0; k < 2; k++) begin
          wr(8'(LIC_VIRT_BASE + i), k ? 16'($urandom_range(65535, 1)) : 0);
          tick_chk();
        end
      end
    end
    $display("test combine done");
    wr(8'h45, 16'h0003);
    wr(8'h95, 16'h0001);
    tick_chk();
    wr(8'h95, 16'h0000);
    tick_chk();
    wr(8'h95, 16'h0001);
    repeat (20) tick_chk();
    for (int j = 0; j < 8; j++) begin
      rv = 16'($urandom);
      @(posedge sys_clk);
      panel_idx <= 5'(j * 2);
      panel_wdata <= rv;
      panel_wr <= 1'b1;
      reg_addr <= 8'(LIC_VIRT_BASE + j);
      reg_wdata <= ~rv;
      reg_wr <= j[0];
      @(posedge sys_clk);
      panel_wr <= 1'b0;
      reg_wr <= 1'b0;
      #1;
      saved(j[0] ? j : j * 2, j[0] ? ~rv : rv);
      tick_chk();
      rchk(8'(LIC_VIRT_BASE + (j[0] ? j : j * 2)), j[0] ? ~rv : rv);
    end
    @(posedge sys_clk);
    nv_load <= 1'b1;
    nv_idx <= 5'h13;
    nv_data <= 16'hBEEF;
    @(posedge sys_clk);
    nv_load <= 1'b0;
    #1;
    vmod[19] = 16'hBEEF;
    chk_word(16'h0000, {15'h0000, nv_save});
    rchk(8'hA3, 16'hBEEF);
    $display("test panel done");
    for (int j = 0; j < 14; j++) begin
      @(posedge sys_clk);
      g_mask <= j == 13 ? 14'h3FFF : 14'(1 << j);
      g_len <= 16'($urandom_range(2000, 1));
      g_go <= 1'b1;
      @(posedge sys_clk);
      g_go <= 1'b0;
      #1;
      for (int t = 0; t < 3000 && g_busy; t++) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      chk_word(16'h0000, {2'b00, contact_closed});
      rchk(LIC_CONT_ADDR, 16'h0000);
      tick_chk();
    end
    $display("test contact done");
    wr(8'h42, 16'h0003);
    wr(8'h43, 16'h0003);
    foreach (cfg[c]) begin
      wr(LIC_BRK_ADDR, 16'(cfg[c]));
      rchk(LIC_BRK_ADDR, 16'(cfg[c]));
      for (int k = 0; k < 4; k++) begin
        if (c == 3 && (k == 0 || k == 3)) continue;
        wr(8'h92, 16'(k & 1));
        wr(8'h93, 16'(k >> 1));
        repeat (3) @(posedge sys_clk);
        #1;
        l = exp_logic();
        aok = cfg[c][11] && cfg[c][10:6] < 14;
        bok = cfg[c][5] && cfg[c][4:0] < 14;
        la = l[cfg[c][10:6]];
        lb = l[cfg[c][4:0]];
        en = aok | bok;
        ecl = aok ? la : bok & !lb;
        eop = aok ? (bok ? lb : !la) : bok & lb;
        chk_word({12'h000, en, ecl, eop, en},
          {12'h000, b_en, b_cl, b_op, b_al});
        rchk(LIC_LOGIC_ADDR, l[15:0]);
        rchk(LIC_STAT_ADDR, {l[19:16], eop, ecl, en, 9'h000});
      end
    end
    $display("test breaker done");
    final_report();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    $display("watchdog expired");
    final_report();
  end
endmodule
`default_nettype wire
